// ===== hw/cfd_cfg_if.sv
`timescale 1ns/1ps
interface cfd_cfg_if;
	import cfd_pkg::*;
	logic boot_write_ok; // Boot segment writable
	logic boot_present; // Boot segment exists
	cfd_sec_t boot_sec; // Boot security level
	logic [23:0] boot_end; // Last boot word address
	logic gen_write_ok; // General segment writable
	cfd_sec_t gen_sec; // General security level
	logic wdt_force_on; // Watchdog forced on
	logic wdt_window; // Windowed mode
	logic [7:0] wdt_pre_div; // Prescaler ratio
	logic [15:0] wdt_post_div; // Postscaler ratio
	logic [7:0] powerup_delay_timer_units; // Power-up delay in ms
	modport drv (output boot_write_ok, boot_present, boot_sec, boot_end, gen_write_ok,
		gen_sec, wdt_force_on, wdt_window, wdt_pre_div, wdt_post_div, powerup_delay_timer_units);
	modport use_p (input boot_write_ok, boot_present, boot_sec, boot_end, gen_write_ok,
		gen_sec, wdt_force_on, wdt_window, wdt_pre_div, wdt_post_div, powerup_delay_timer_units);
endinterface

// ===== hw/cfd_decode.sv
`timescale 1ns/1ps
module cfd_decode import cfd_pkg::*; (
	input wire logic [15:0] boot_word_i, // Captured boot word
	input wire logic [15:0] gen_word_i, // Captured general word
	input wire logic [15:0] wdt_word_i, // Captured watchdog word
	input wire logic [15:0] por_word_i, // Captured power-on word
	cfd_cfg_if.drv cfg // Decoded settings
);
	logic [2:0] bss;
	logic [1:0] gss;
	logic [3:0] post;
	logic [2:0] powerup_delay_timer;

	// Field extraction and decode
	always_comb begin
		bss = boot_word_i[BOOT_SIZE_LSB +: 3];
		gss = gen_word_i[GEN_LEVEL_LSB +: 2];
		post = wdt_word_i[WDT_POST_LSB +: 4];
		powerup_delay_timer = por_word_i[POR_POWERUP_DELAY_TIMER_LSB +: 3];
		cfg.boot_write_ok = boot_word_i[BOOT_WP_BIT];
		cfg.boot_present = 1'b1;
		cfg.boot_sec = CFD_SEC_NONE;
		cfg.boot_end = 24'h00_0000;
		case (bss)
			BSS_STD_SMALL: begin
				cfg.boot_sec = CFD_SEC_STD;
				cfg.boot_end = BOOT_END_SMALL;
			end
			BSS_HIGH_SMALL: begin
				cfg.boot_sec = CFD_SEC_HIGH;
				cfg.boot_end = BOOT_END_SMALL;
			end
			BSS_STD_MEDIUM: begin
				cfg.boot_sec = CFD_SEC_STD;
				cfg.boot_end = BOOT_END_MEDIUM;
			end
			BSS_HIGH_MEDIUM: begin
				cfg.boot_sec = CFD_SEC_HIGH;
				cfg.boot_end = BOOT_END_MEDIUM;
			end
			default: cfg.boot_present = 1'b0;
		endcase
		cfg.gen_write_ok = gen_word_i[GEN_WP_BIT];
		case (gss)
			GSS_NONE: cfg.gen_sec = CFD_SEC_NONE;
			GSS_STD: cfg.gen_sec = CFD_SEC_STD;
			default: cfg.gen_sec = CFD_SEC_RSVD;
		endcase
		cfg.wdt_force_on = wdt_word_i[WDT_FORCE_BIT];
		cfg.wdt_window = ~wdt_word_i[WDT_WIN_OFF_BIT];
		cfg.wdt_pre_div = wdt_word_i[WDT_PRE_BIT] ? WDT_PRE_HIGH : WDT_PRE_LOW;
		cfg.wdt_post_div = 16'h0001 << post;
		cfg.powerup_delay_timer_units = (powerup_delay_timer == 3'h0) ? 8'h00 : (8'h01 << powerup_delay_timer);
	end
endmodule

// ===== hw/cfd_pkg.sv
package cfd_pkg;
	// Clock and power-up timing
	localparam int CLK_FREQ_HZ = 10_000_000;
	localparam int POWERUP_DELAY_TIMER_UNIT_MS = 1;
	localparam int POWERUP_DELAY_TIMER_UNIT_CYCLES = CLK_FREQ_HZ / 1000 * POWERUP_DELAY_TIMER_UNIT_MS;
	// Word widths
	localparam int CFG_WORD_W = 24;
	localparam int CFG_DATA_W = 16;
	// Register byte offsets
	localparam logic [4:0] OFS_BOOT_CFG = 5'h00;
	localparam logic [4:0] OFS_GEN_CFG = 5'h04;
	localparam logic [4:0] OFS_WDT_CFG = 5'h08;
	localparam logic [4:0] OFS_POR_CFG = 5'h0C;
	localparam logic [4:0] OFS_CTRL = 5'h10;
	localparam logic [4:0] OFS_STATUS = 5'h14;
	// Field positions
	localparam int BOOT_WP_BIT = 0;
	localparam int BOOT_SIZE_LSB = 1;
	localparam int GEN_WP_BIT = 0;
	localparam int GEN_LEVEL_LSB = 1;
	localparam int WDT_POST_LSB = 0;
	localparam int WDT_PRE_BIT = 4;
	localparam int WDT_WIN_OFF_BIT = 6;
	localparam int WDT_FORCE_BIT = 7;
	localparam int POR_POWERUP_DELAY_TIMER_LSB = 0;
	localparam int CTRL_SOFT_WDT_BIT = 0;
	// Boot size codes
	localparam logic [2:0] BSS_STD_SMALL = 3'h6;
	localparam logic [2:0] BSS_HIGH_SMALL = 3'h2;
	localparam logic [2:0] BSS_STD_MEDIUM = 3'h5;
	localparam logic [2:0] BSS_HIGH_MEDIUM = 3'h1;
	localparam logic [23:0] BOOT_END_SMALL = 24'h00_03FF;
	localparam logic [23:0] BOOT_END_MEDIUM = 24'h00_0FFF;
	// General level codes
	localparam logic [1:0] GSS_NONE = 2'h3;
	localparam logic [1:0] GSS_STD = 2'h2;
	// Watchdog prescaler ratios
	localparam logic [7:0] WDT_PRE_HIGH = 8'h80;
	localparam logic [7:0] WDT_PRE_LOW = 8'h20;
	// Debug resources
	localparam int DBG_PAIRS = 3;
	localparam logic [9:0] DBG_RAM_BYTES = 10'h050;
	// Reset values
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam logic CTRL_SOFT_WDT_RESET = 1'b0;
	// Security levels of a segment
	typedef enum logic [1:0] {CFD_SEC_NONE, CFD_SEC_STD, CFD_SEC_HIGH, CFD_SEC_RSVD} cfd_sec_t;
endpackage

// ===== hw/cfd_powerup_delay_timer.sv
`timescale 1ns/1ps
module cfd_powerup_delay_timer import cfd_pkg::*; #(
	parameter int UNIT_CYCLES = POWERUP_DELAY_TIMER_UNIT_CYCLES // Cycles per ms
) (
	input wire logic clk_sys_i, // System clock
	input wire logic reset_n_i, // Sync reset, low
	input wire logic start_i, // Start pulse
	input wire logic [7:0] units_i, // Delay in ms, 0 = none
	output logic done_o // Delay elapsed
);
	localparam int CW = $clog2(UNIT_CYCLES + 1);
	typedef enum logic [1:0] {CFD_PT_IDLE, CFD_PT_COUNT, CFD_PT_DONE} cfd_pt_st_t;
	cfd_pt_st_t st_reg, st_next; // Timer state
	logic [CW-1:0] cyc_reg, cyc_next; // Cycles within a ms
	logic [7:0] ms_reg, ms_next; // Elapsed ms
	logic done_reg, done_next; // Done flag

	// Next-state logic
	always_comb begin
		st_next = st_reg;
		cyc_next = cyc_reg;
		ms_next = ms_reg;
		done_next = done_reg;
		case (st_reg)
			CFD_PT_IDLE: begin
				if (start_i) begin
					cyc_next = '0;
					ms_next = 8'h00;
					if (units_i == 8'h00) begin
						st_next = CFD_PT_DONE;
						done_next = 1'b1;
					end else begin
						st_next = CFD_PT_COUNT;
					end
				end
			end
			CFD_PT_COUNT: begin
				if (cyc_reg == CW'(UNIT_CYCLES - 1)) begin
					cyc_next = '0;
					ms_next = ms_reg + 8'h01;
					if (ms_reg + 8'h01 == units_i) begin
						st_next = CFD_PT_DONE;
						done_next = 1'b1;
					end
				end else begin
					cyc_next = cyc_reg + CW'(1);
				end
			end
			CFD_PT_DONE: done_next = 1'b1;
			default: st_next = CFD_PT_IDLE;
		endcase
	end

	// State registers
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			st_reg <= CFD_PT_IDLE;
			cyc_reg <= '0;
			ms_reg <= 8'h00;
			done_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			cyc_reg <= cyc_next;
			ms_reg <= ms_next;
			done_reg <= done_next;
		end
	end

	assign done_o = done_reg;
endmodule

// ===== hw/cfd_top.sv
`timescale 1ns/1ps
module cfd_top import cfd_pkg::*; #(
	parameter int POWERUP_DELAY_TIMER_UNIT_CYC = POWERUP_DELAY_TIMER_UNIT_CYCLES, // Cycles per ms of delay
	parameter logic [23:0] IVT_END = 24'h00_00FF, // Last vector word
	parameter logic [23:0] FLASH_END = 24'h00_1FFF // Last flash word
) (
	input wire logic clk_sys_i, // System clock
	input wire logic reset_n_i, // Sync reset, low
	input wire logic [23:0] nv_boot_word_i, // Stored boot word
	input wire logic [23:0] nv_gen_word_i, // Stored general word
	input wire logic [23:0] nv_wdt_word_i, // Stored watchdog word
	input wire logic [23:0] nv_por_word_i, // Stored power-on word
	input wire logic nv_debug_en_i, // Stored debug enable
	input wire logic [1:0] nv_debug_pair_i, // Stored debug pair
	input wire logic [4:0] avs_address_i, // Byte address
	input wire logic avs_read_i, // Read request
	input wire logic avs_write_i, // Write request
	input wire logic [31:0] avs_writedata_i, // Write data
	input wire logic [3:0] avs_byteenable_i, // Byte lanes
	output logic [31:0] avs_readdata_o, // Read data
	output logic avs_waitrequest_o, // Stall
	input wire logic flash_wr_req_i, // Flash write attempt
	input wire logic [23:0] flash_wr_addr_i, // Flash word address
	output logic flash_wr_allow_o, // Write may proceed
	input wire logic [9:0] ram_addr_i, // Data RAM byte address
	output logic ram_user_ok_o, // RAM byte open to user
	output logic wdt_run_o, // Watchdog running
	output logic low_power_rc_osc_on_o, // Low-power RC kept on
	output logic wdt_window_o, // Windowed mode
	output logic [7:0] wdt_pre_div_o, // Prescaler ratio
	output logic [15:0] wdt_post_div_o, // Postscaler ratio
	output logic powerup_done_o, // Power-up delay over
	output cfd_sec_t boot_sec_o, // Boot security level
	output cfd_sec_t gen_sec_o, // General security level
	input wire logic dbg_tx_i, // Debug engine data out
	input wire logic dbg_tx_en_i, // Debug engine drives
	output logic dbg_rx_o, // Data from chosen pin
	output logic dbg_clk_o, // Clock from chosen pin
	input wire logic [DBG_PAIRS-1:0] dbg_pin_data_i, // Data pins in
	output logic [DBG_PAIRS-1:0] dbg_pin_data_o, // Data pins out
	output logic [DBG_PAIRS-1:0] dbg_pin_data_oe_n_o, // Data enable, low
	input wire logic [DBG_PAIRS-1:0] dbg_pin_clk_i, // Clock pins in
	output logic [DBG_PAIRS-1:0] dbg_pin_lock_o, // Pins withheld
	output logic prog_pins_shared_o // Programming pins in debug use
);
	typedef enum logic {CFD_ST_LOAD, CFD_ST_RUN} cfd_st_t;

	// Capture state
	cfd_st_t st_reg, st_next; // Load or run
	logic [15:0] boot_w_reg, boot_w_next; // Boot word
	logic [15:0] gen_w_reg, gen_w_next; // General word
	logic [15:0] wdt_w_reg, wdt_w_next; // Watchdog word
	logic [15:0] por_w_reg, por_w_next; // Power-on word
	logic dbg_en_reg, dbg_en_next; // Debug enabled
	logic [1:0] dbg_sel_reg, dbg_sel_next; // Chosen pair
	logic start_reg, start_next; // Timer start pulse
	logic loaded_reg, loaded_next; // Capture done

	// Bus state
	logic soft_wdt_reg, soft_wdt_next; // Software watchdog enable
	logic wait_reg, wait_next; // Waitrequest
	logic [31:0] rdata_reg, rdata_next; // Read data

	// Output registers
	logic flash_ok_reg, flash_ok_next;
	logic ram_ok_reg, ram_ok_next;
	logic wdt_run_reg, wdt_run_next;
	logic low_power_rc_osc_reg, low_power_rc_osc_next;
	logic win_reg, win_next;
	logic [7:0] pre_reg, pre_next;
	logic [15:0] post_reg, post_next;
	cfd_sec_t bsec_reg, bsec_next;
	cfd_sec_t gsec_reg, gsec_next;
	logic rx_reg, rx_next;
	logic clk_reg, clk_next;
	logic shared_reg, shared_next;
	logic [DBG_PAIRS-1:0] pout_reg, pout_next;
	logic [DBG_PAIRS-1:0] poe_n_reg, poe_n_next;
	logic [DBG_PAIRS-1:0] lock_reg, lock_next;

	// Per-pair helpers
	logic [DBG_PAIRS-1:0] pair_hot; // Pair chosen and active
	logic [DBG_PAIRS-1:0] rx_bits; // Masked data in
	logic [DBG_PAIRS-1:0] clk_bits; // Masked clock in
	logic [1:0] sel_eff; // Chosen pair, spare code folded
	logic pt_done; // Power-up timer done
	logic [31:0] status_word; // Status readback
	logic [CFG_DATA_W-1:0] ctrl_word; // Control readback
	logic acc; // Bus access this cycle

	cfd_cfg_if cfg (); // Decoded settings

	// Decoder of captured words
	cfd_decode u_decode (
		.boot_word_i(boot_w_reg),
		.gen_word_i(gen_w_reg),
		.wdt_word_i(wdt_w_reg),
		.por_word_i(por_w_reg),
		.cfg(cfg)
	);

	// Power-up delay timer
	cfd_powerup_delay_timer #(
		.UNIT_CYCLES(POWERUP_DELAY_TIMER_UNIT_CYC)
	) u_powerup_delay_timer (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.start_i(start_reg),
		.units_i(cfg.powerup_delay_timer_units),
		.done_o(pt_done)
	);

	// Spare pair code falls back to the primary pair
	assign sel_eff = (dbg_sel_reg == 2'h3) ? 2'h0 : dbg_sel_reg;

	// Pin pair steering, one slice per pair
	genvar k;
	generate
		for (k = 0; k < DBG_PAIRS; k = k + 1) begin : g_pair
			assign pair_hot[k] = dbg_en_reg && (sel_eff == 2'(k));
			assign rx_bits[k] = pair_hot[k] & dbg_pin_data_i[k];
			assign clk_bits[k] = pair_hot[k] & dbg_pin_clk_i[k];
			assign pout_next[k] = pair_hot[k] & dbg_tx_i;
			assign poe_n_next[k] = ~(pair_hot[k] & dbg_tx_en_i);
			assign lock_next[k] = pair_hot[k];
		end
	endgenerate

	// Readback words
	assign ctrl_word = CFG_DATA_W'(soft_wdt_reg) << CTRL_SOFT_WDT_BIT;
	assign status_word = {24'h00_0000, loaded_reg, cfg.gen_sec == CFD_SEC_RSVD,
		dbg_sel_reg, dbg_en_reg, pt_done, low_power_rc_osc_reg, wdt_run_reg};
	assign acc = (avs_read_i | avs_write_i) & wait_reg;

	// Capture, bus and output next values
	always_comb begin
		st_next = st_reg;
		boot_w_next = boot_w_reg;
		gen_w_next = gen_w_reg;
		wdt_w_next = wdt_w_reg;
		por_w_next = por_w_reg;
		dbg_en_next = dbg_en_reg;
		dbg_sel_next = dbg_sel_reg;
		start_next = 1'b0;
		loaded_next = loaded_reg;
		soft_wdt_next = soft_wdt_reg;
		wait_next = 1'b1;
		rdata_next = rdata_reg;

		// Words taken once after reset, then frozen
		case (st_reg)
			CFD_ST_LOAD: begin
				boot_w_next = nv_boot_word_i[CFG_DATA_W-1:0];
				gen_w_next = nv_gen_word_i[CFG_DATA_W-1:0];
				wdt_w_next = nv_wdt_word_i[CFG_DATA_W-1:0];
				por_w_next = nv_por_word_i[CFG_DATA_W-1:0];
				dbg_en_next = nv_debug_en_i;
				dbg_sel_next = nv_debug_pair_i;
				start_next = 1'b1;
				loaded_next = 1'b1;
				st_next = CFD_ST_RUN;
			end
			CFD_ST_RUN: st_next = CFD_ST_RUN;
			default: st_next = CFD_ST_LOAD;
		endcase

		// One wait cycle, then the answer
		if (acc) begin
			wait_next = 1'b0;
			case (avs_address_i)
				OFS_BOOT_CFG: rdata_next = {16'h0000, boot_w_reg};
				OFS_GEN_CFG: rdata_next = {16'h0000, gen_w_reg};
				OFS_WDT_CFG: rdata_next = {16'h0000, wdt_w_reg};
				OFS_POR_CFG: rdata_next = {16'h0000, por_w_reg};
				OFS_CTRL: rdata_next = {16'h0000, ctrl_word};
				OFS_STATUS: rdata_next = status_word;
				default: rdata_next = 32'h0000_0000;
			endcase
		end

		// Only the control word is writable
		if (avs_write_i && !wait_reg && avs_address_i == OFS_CTRL && avs_byteenable_i[0]) begin
			soft_wdt_next = avs_writedata_i[CTRL_SOFT_WDT_BIT];
		end

		// Watchdog run and oscillator keep-on
		wdt_run_next = cfg.wdt_force_on | soft_wdt_reg;
		low_power_rc_osc_next = cfg.wdt_force_on | soft_wdt_reg;
		win_next = cfg.wdt_window;
		pre_next = cfg.wdt_pre_div;
		post_next = cfg.wdt_post_div;
		bsec_next = cfg.boot_sec;
		gsec_next = cfg.gen_sec;

		// Flash write gate by segment
		flash_ok_next = 1'b0;
		if (flash_wr_req_i && loaded_reg) begin
			if (cfg.boot_present && flash_wr_addr_i > IVT_END
				&& flash_wr_addr_i <= cfg.boot_end) begin
				flash_ok_next = cfg.boot_write_ok;
			end else if (flash_wr_addr_i <= FLASH_END) begin
				flash_ok_next = cfg.gen_write_ok;
			end
		end

		// RAM bytes held back for the debugger
		ram_ok_next = !(dbg_en_reg && ram_addr_i < DBG_RAM_BYTES);

		// Chosen pair to the debug engine
		rx_next = |rx_bits;
		clk_next = |clk_bits;
		shared_next = dbg_en_reg && (sel_eff == 2'h0);
	end

	// Register update
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			st_reg <= CFD_ST_LOAD;
			boot_w_reg <= CFG_RESET;
			gen_w_reg <= CFG_RESET;
			wdt_w_reg <= CFG_RESET;
			por_w_reg <= CFG_RESET;
			dbg_en_reg <= 1'b0;
			dbg_sel_reg <= 2'h0;
			start_reg <= 1'b0;
			loaded_reg <= 1'b0;
			soft_wdt_reg <= CTRL_SOFT_WDT_RESET;
			wait_reg <= 1'b1;
			rdata_reg <= 32'h0000_0000;
			flash_ok_reg <= 1'b0;
			ram_ok_reg <= 1'b1;
			wdt_run_reg <= 1'b0;
			low_power_rc_osc_reg <= 1'b0;
			win_reg <= 1'b0;
			pre_reg <= 8'h00;
			post_reg <= 16'h0000;
			bsec_reg <= CFD_SEC_NONE;
			gsec_reg <= CFD_SEC_NONE;
			rx_reg <= 1'b0;
			clk_reg <= 1'b0;
			shared_reg <= 1'b0;
			pout_reg <= '0;
			poe_n_reg <= '1;
			lock_reg <= '0;
		end else begin
			st_reg <= st_next;
			boot_w_reg <= boot_w_next;
			gen_w_reg <= gen_w_next;
			wdt_w_reg <= wdt_w_next;
			por_w_reg <= por_w_next;
			dbg_en_reg <= dbg_en_next;
			dbg_sel_reg <= dbg_sel_next;
			start_reg <= start_next;
			loaded_reg <= loaded_next;
			soft_wdt_reg <= soft_wdt_next;
			wait_reg <= wait_next;
			rdata_reg <= rdata_next;
			flash_ok_reg <= flash_ok_next;
			ram_ok_reg <= ram_ok_next;
			wdt_run_reg <= wdt_run_next;
			low_power_rc_osc_reg <= low_power_rc_osc_next;
			win_reg <= win_next;
			pre_reg <= pre_next;
			post_reg <= post_next;
			bsec_reg <= bsec_next;
			gsec_reg <= gsec_next;
			rx_reg <= rx_next;
			clk_reg <= clk_next;
			shared_reg <= shared_next;
			pout_reg <= pout_next;
			poe_n_reg <= poe_n_next;
			lock_reg <= lock_next;
		end
	end

	// Outputs straight from flops
	assign avs_readdata_o = rdata_reg;
	assign avs_waitrequest_o = wait_reg;
	assign flash_wr_allow_o = flash_ok_reg;
	assign ram_user_ok_o = ram_ok_reg;
	assign wdt_run_o = wdt_run_reg;
	assign low_power_rc_osc_on_o = low_power_rc_osc_reg;
	assign wdt_window_o = win_reg;
	assign wdt_pre_div_o = pre_reg;
	assign wdt_post_div_o = post_reg;
	assign powerup_done_o = pt_done;
	assign boot_sec_o = bsec_reg;
	assign gen_sec_o = gsec_reg;
	assign dbg_rx_o = rx_reg;
	assign dbg_clk_o = clk_reg;
	assign dbg_pin_data_o = pout_reg;
	assign dbg_pin_data_oe_n_o = poe_n_reg;
	assign dbg_pin_lock_o = lock_reg;
	assign prog_pins_shared_o = shared_reg;
endmodule

// ===== sim/cfd_dbg_host.sv
`timescale 1ns/1ps
module cfd_dbg_host import cfd_pkg::*; (
	input wire logic clk_sys_i, // System clock
	input wire logic active_i, // Host frame in progress
	input wire logic [1:0] sel_i, // Pair the host is wired to
	input wire logic host_drv_i, // Host drives data
	input wire logic host_dat_i, // Host data bit
	input wire logic [DBG_PAIRS-1:0] dev_dat_i, // Device data out
	input wire logic [DBG_PAIRS-1:0] dev_oe_n_i, // Device enable, low
	output logic [DBG_PAIRS-1:0] pin_clk_o, // Clock wires
	output logic [DBG_PAIRS-1:0] pin_dat_o // Data wires
);
	logic clk_reg = 1'b0; // Host debug clock
	logic [DBG_PAIRS-1:0] last_reg = '0; // Last wire levels
	// Host clock runs only inside frames
	always_ff @(posedge clk_sys_i) begin
		clk_reg <= active_i ? ~clk_reg : 1'b0;
		last_reg <= pin_dat_o;
	end
	// Wire levels; an undriven wire shows the inverse of its last level
	always_comb begin
		for (int k = 0; k < DBG_PAIRS; k++) begin
			pin_clk_o[k] = (k == sel_i) && clk_reg;
			if (!dev_oe_n_i[k]) pin_dat_o[k] = dev_dat_i[k];
			else if (k == sel_i && host_drv_i) pin_dat_o[k] = host_dat_i;
			else pin_dat_o[k] = ~last_reg[k];
		end
	end
endmodule

// ===== sim/cfd_top_checker.sv
`timescale 1ns/1ps
module cfd_top_checker import cfd_pkg::*; #(
	parameter logic [23:0] FLASH_END = 24'h00_1FFF // Last flash word
) (
	input wire logic clk_sys_i, // Clock
	input wire logic reset_n_i, // Sync reset, low
	input wire logic avs_read_i, // Read request
	input wire logic avs_write_i, // Write request
	input wire logic avs_waitrequest_o, // Stall
	input wire logic [23:0] flash_wr_addr_i, // Flash address
	input wire logic flash_wr_allow_o, // Write gate
	input wire logic [9:0] ram_addr_i, // RAM address
	input wire logic ram_user_ok_o, // RAM gate
	input wire logic wdt_run_o, // Watchdog running
	input wire logic low_power_rc_osc_on_o, // RC kept on
	input wire logic [7:0] wdt_pre_div_o, // Prescaler
	input wire logic [15:0] wdt_post_div_o, // Postscaler
	input cfd_sec_t boot_sec_o, // Boot level
	input cfd_sec_t gen_sec_o, // General level
	input wire logic [DBG_PAIRS-1:0] dbg_pin_data_oe_n_o, // Data enables
	input wire logic [DBG_PAIRS-1:0] dbg_pin_lock_o, // Pins withheld
	input wire logic prog_pins_shared_o // Programming pins shared
);
	logic [1:0] up_reg; // Edges since release, saturating
	logic [1:0] up_next; // Next count
	// Count edges after reset release
	always_comb begin
		up_next = !reset_n_i ? 2'h0 : ((up_reg == 2'h3) ? up_reg : up_reg + 2'h1);
	end
	always_ff @(posedge clk_sys_i) begin
		up_reg <= up_next;
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	// Bus request taken, then one cycle of answer
	sequence s_taken;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence s_answer;
		!avs_waitrequest_o ##1 avs_waitrequest_o;
	endsequence
	a_bus_one_wait: assert property (s_taken |=> s_answer)
		else $error("bus answer timing wrong");
	a_wdt_rc_same: assert property (wdt_run_o == low_power_rc_osc_on_o)
		else $error("watchdog and RC disagree");
	a_pre_div_legal: assert property ((up_reg == 2'h3) |->
		(wdt_pre_div_o == WDT_PRE_HIGH || wdt_pre_div_o == WDT_PRE_LOW))
		else $error("prescaler ratio illegal");
	a_post_pow_two: assert property ((up_reg == 2'h3) |-> $onehot(wdt_post_div_o))
		else $error("postscaler not a power of two");
	a_cfg_held: assert property ((up_reg == 2'h3) |=> $stable(boot_sec_o) &&
		$stable(gen_sec_o) && $stable(wdt_post_div_o))
		else $error("settings changed at run time");
	a_boot_not_rsvd: assert property ((up_reg == 2'h3) |-> boot_sec_o != CFD_SEC_RSVD)
		else $error("boot level reserved");
	a_one_driver: assert property ($countones(~dbg_pin_data_oe_n_o) <= 1)
		else $error("more than one data pin driven");
	a_shared_locks: assert property (prog_pins_shared_o |-> dbg_pin_lock_o[0])
		else $error("shared pins not withheld");
	a_flash_above_end: assert property ((flash_wr_addr_i > FLASH_END) |=> !flash_wr_allow_o)
		else $error("write allowed beyond flash");
	a_ram_debug_hide: assert property ((|dbg_pin_lock_o && ram_addr_i < 10'h050)
		|=> !ram_user_ok_o)
		else $error("debug RAM open to user");
	a_ram_high_open: assert property ((ram_addr_i >= 10'h050) |=> ram_user_ok_o)
		else $error("user RAM closed");
endmodule
bind cfd_top cfd_top_checker #(.FLASH_END(FLASH_END)) chk_u (
	.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
	.flash_wr_addr_i(flash_wr_addr_i), .flash_wr_allow_o(flash_wr_allow_o),
	.ram_addr_i(ram_addr_i), .ram_user_ok_o(ram_user_ok_o), .wdt_run_o(wdt_run_o),
	.low_power_rc_osc_on_o(low_power_rc_osc_on_o), .wdt_pre_div_o(wdt_pre_div_o), .wdt_post_div_o(wdt_post_div_o),
	.boot_sec_o(boot_sec_o), .gen_sec_o(gen_sec_o), .dbg_pin_data_oe_n_o(dbg_pin_data_oe_n_o),
	.dbg_pin_lock_o(dbg_pin_lock_o), .prog_pins_shared_o(prog_pins_shared_o)
);

// ===== sim/cfd_top_tb.sv
`timescale 1ns/1ps
module cfd_top_tb import cfd_pkg::*; ;
	localparam int PW = 4; // Cycles per ms in this run
	logic clk_sys_i = 1'b0; // Clock
	logic reset_n_i = 1'b0; // Reset, low
	logic [23:0] nvb = '0, nvg = '0, nvw = '0, nvp = '0; // Stored words
	logic den = 1'b0, rd = 1'b0, wr = 1'b0, freq = 1'b0, tx = 1'b0, txe = 1'b0;
	logic [1:0] dpr = '0, hsel = '0; // Pair selects
	logic hact = 1'b0, hdrv = 1'b0, hdat = 1'b0; // Host controls
	logic [4:0] addr = '0; // Bus address
	logic [3:0] be = 4'hF; // Byte lanes
	logic [31:0] wdat = '0, rdat, rv; // Bus data
	logic [23:0] faddr = '0; // Flash address
	logic [9:0] raddr = '0; // RAM address
	logic wt, fok, rok, run, low_power_rc_osc, win, pdone, rx, dclk, shared;
	logic [7:0] pre; // Prescaler seen
	logic [15:0] post; // Postscaler seen
	cfd_sec_t bsec, gsec; // Levels seen
	logic [2:0] pdi, pdo, poen, pci, lock; // Debug pins
	int err_count = 0;
	int n_tests = 0;
	// Clock
	initial begin
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	cfd_top #(.POWERUP_DELAY_TIMER_UNIT_CYC(PW)) dut_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
		.nv_boot_word_i(nvb), .nv_gen_word_i(nvg), .nv_wdt_word_i(nvw), .nv_por_word_i(nvp),
		.nv_debug_en_i(den), .nv_debug_pair_i(dpr), .avs_address_i(addr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wt), .flash_wr_req_i(freq),
		.flash_wr_addr_i(faddr), .flash_wr_allow_o(fok), .ram_addr_i(raddr),
		.ram_user_ok_o(rok), .wdt_run_o(run), .low_power_rc_osc_on_o(low_power_rc_osc), .wdt_window_o(win),
		.wdt_pre_div_o(pre), .wdt_post_div_o(post), .powerup_done_o(pdone),
		.boot_sec_o(bsec), .gen_sec_o(gsec), .dbg_tx_i(tx), .dbg_tx_en_i(txe),
		.dbg_rx_o(rx), .dbg_clk_o(dclk), .dbg_pin_data_i(pdi), .dbg_pin_data_o(pdo),
		.dbg_pin_data_oe_n_o(poen), .dbg_pin_clk_i(pci), .dbg_pin_lock_o(lock),
		.prog_pins_shared_o(shared));
	cfd_dbg_host host_u (.clk_sys_i(clk_sys_i), .active_i(hact), .sel_i(hsel),
		.host_drv_i(hdrv), .host_dat_i(hdat), .dev_dat_i(pdo), .dev_oe_n_i(poen),
		.pin_clk_o(pci), .pin_dat_o(pdi));
	// Compare and count
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task report_and_stop;
		if (err_count == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// One bus access, held until waitrequest is sampled low
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_sys_i);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdat <= d;
		do begin
			@(posedge clk_sys_i);
		end while (wt !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	// Present flash and RAM addresses, settle on the answer cycle
	task probe(input logic [23:0] fa, input logic [9:0] ra);
		@(posedge clk_sys_i);
		freq <= 1'b1;
		faddr <= fa;
		raddr <= ra;
		@(posedge clk_sys_i);
		#1;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	// Load stored words through a reset and time the power-up delay
	task cfg(input logic [15:0] b, g, w, input logic [2:0] p, input logic en, input logic [1:0] pr);
		int u;
		int c;
		@(posedge clk_sys_i);
		reset_n_i <= 1'b0;
		nvb <= {8'hA5, b};
		nvg <= {8'h5A, g};
		nvw <= {8'hC3, w};
		nvp <= {8'h3C, 13'h0000, p};
		den <= en;
		dpr <= pr;
		hsel <= (pr == 2'h3) ? 2'h0 : pr;
		repeat (6) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		c = 0;
		do begin
			@(posedge clk_sys_i);
			c++;
		end while (pdone !== 1'b1 && c < 1000);
		u = (p == 3'h0) ? 0 : (1 << p);
		chk("powerup_delay_timer", c >= u * PW && c <= u * PW + 6, 1);
		tick(2);
	endtask
	initial begin
		logic [2:0] bs;
		logic pres;
		cfd_sec_t sec;
		// Every boot size, timer code, prescale, window and force setting
		for (int i = 0; i < 8; i++) begin
			bs = i[2:0];
			cfg({12'h000, bs, i[0]}, 16'h0007, {8'h00, i[2], i[1], 1'b0, i[0], bs, 1'b1}, bs, 0, 0);
			pres = bs[1] ^ bs[0];
			sec = (bs == 3'h6 || bs == 3'h5) ? CFD_SEC_STD : (pres ? CFD_SEC_HIGH : CFD_SEC_NONE);
			chk("boot_sec", bsec, sec);
			probe(24'h00_03FF, 10'h000);
			chk("flash_small", fok, pres ? i[0] : 1'b1);
			chk("ram_free", rok, 1);
			probe(24'h00_0400, 10'h3FF);
			chk("flash_medium", fok, (pres && !bs[1]) ? i[0] : 1'b1);
			chk("gen_sec", gsec, CFD_SEC_NONE);
			chk("wdt_run", run, i[2]);
			chk("low_power_rc_osc", low_power_rc_osc, i[2]);
			chk("window", win, !i[1]);
			chk("pre", pre, i[0] ? 8'h80 : 8'h20);
			chk("post", post, 16'h0001 << (2 * i + 1));
			bus(0, OFS_BOOT_CFG, 0, rv);
			chk("boot_reg", rv, {28'h000_0000, bs, i[0]});
		end
		// Software watchdog, reserved general level, alternate debug pair
		cfg(16'h0001, 16'h0002, 16'h0000, 3'h0, 1, 1);
		chk("gen_rsvd", gsec, CFD_SEC_RSVD);
		probe(24'h00_1000, 10'h04F);
		chk("gen_wp", fok, 0);
		chk("ram_dbg", rok, 0);
		probe(24'h00_2000, 10'h050);
		chk("beyond", fok, 0);
		chk("ram_open", rok, 1);
		chk("post_one", post, 1);
		chk("lock_alt", lock, 3'b010);
		chk("shared_alt", shared, 0);
		for (int j = 1; j >= 0; j--) begin
			bus(1, OFS_CTRL, j, rv);
			tick(2);
			chk("soft_run", run, j);
			chk("soft_rc", low_power_rc_osc, j);
			bus(0, OFS_CTRL, 0, rv);
			chk("ctrl_rd", rv, j);
		end
		// Control write without its byte lane must be ignored
		be <= 4'hE;
		bus(1, OFS_CTRL, 1, rv);
		tick(2);
		chk("be_off", run, 0);
		be <= 4'hF;
		bus(0, OFS_STATUS, 0, rv);
		chk("status", rv, 32'h0000_00DC);
		bus(0, 5'h18, 0, rv);
		chk("unmapped", rv, 0);
		@(posedge clk_sys_i);
		hact <= 1'b1;
		hdrv <= 1'b1;
		for (int j = 0; j < 4; j++) begin
			hdat <= j[0];
			@(posedge clk_sys_i);
			#1;
			chk("dbg_clk", dclk, j[0]);
			chk("dbg_rx", rx, j[0]);
		end
		hact <= 1'b0;
		// Primary pair through code 3, forced watchdog, settings frozen
		cfg(16'h000D, 16'h0007, 16'h0080, 3'h0, 1, 3);
		chk("shared_pri", shared, 1);
		chk("lock_pri", lock, 3'b001);
		@(posedge clk_sys_i);
		tx <= 1'b1;
		txe <= 1'b1;
		tick(2);
		chk("oe_n", poen, 3'b110);
		chk("pin_out", pdo[0], 1);
		bus(1, OFS_CTRL, 0, rv);
		tick(2);
		chk("forced", run, 1);
		nvb <= 24'h00_0000;
		nvg <= 24'h00_0000;
		nvw <= 24'h00_0000;
		probe(24'h00_0200, 10'h000);
		chk("held_wp", fok, 1);
		chk("held_sec", bsec, CFD_SEC_STD);
		chk("held_run", run, 1);
		report_and_stop;
	end
	// Watchdog on the run
	initial begin
		repeat (30000) @(posedge clk_sys_i);
		err_count++;
		report_and_stop;
	end
endmodule
